//--- design/can_regs_defines.vh
// constants of the can control and status register block
`ifndef CAN_REGS_DEFINES_VH
`define CAN_REGS_DEFINES_VH
// ***********************************
// register byte addresses
// ***********************************
`define A_CTRL_ONE 6'h00
`define A_CTRL_TWO 6'h04
`define A_VEC 6'h08
`define A_FIFO_CTRL 6'h0C
`define A_FIFO_STAT 6'h10
`define A_INTF 6'h14
`define A_INTE 6'h18
`define A_ERRCNT 6'h1C
`define A_TIMING_ONE 6'h20
`define A_TIMING_TWO 6'h24
// ***********************************
// control one fields
// ***********************************
`define B_IDLE_STOP 13
`define B_ABORT 12
`define F_REQ 10:8
`define F_MODE 7:5
`define B_CAPTURE 3
`define B_WINDOW 0
// ***********************************
// modes
// ***********************************
`define M_NORMAL 3'h0
`define M_DISABLE 3'h1
`define M_LOOPBACK 3'h2
`define M_LISTEN 3'h3
`define M_CONFIG 3'h4
`define M_LISTEN_ALL 3'h7
// ***********************************
// flag bit positions
// ***********************************
`define B_INVALID 7
`define B_WAKE 6
`define B_ERROR 5
`define B_FIFO_AF 3
`define B_OVERFLOW 2
`define B_RXBUF 1
`define B_TXBUF 0
`define FLAG_MASK 8'hEF
`define F_ESTATE 13:8
// ***********************************
// interrupt codes
// ***********************************
`define IC_NONE 7'h40
`define IC_ERROR 7'h41
`define IC_WAKE 7'h42
`define IC_OVERFLOW 7'h43
`define IC_FIFO_AF 7'h44
`define IC_RXBASE 7'h08
// ***********************************
// limits and counts
// ***********************************
`define IDLE_BITS 4'hB
`define DN_MAX 5'h11
`define WARN_LEVEL 8'h60
`define PASSIVE_LEVEL 8'h80
`define BUSOFF_LEVEL 8'hFF
`define ERR_STEP 8'h08
`endif

//--- design/can_ctrl_status.v
// control, status, flag and error count registers of a can controller
// Behaviour
// - loopback feeds the internal transmit stream straight into receive
// - loopback releases both bus pins to general port use
// - idle stop set halts the module while the chip idles
// - abort bit signals all buffers, self clears when all aborted
// - mode in force reported read-only at 7:5, reset configuration
// - capture enable gives a capture event per received message
// - window select picks filter window when one, buffer when zero
// - read-only filter bit count, values above 17 invalid
// - filter hit field reports accepting filter 0 to 15
// - interrupt code names pending source, none after reset
// - error state flags at bits 13 down to 8
// - hardware sets flags, software only clears by writing zero
// - flags for invalid, wake, error, almost full, overflow, rx, tx
// - error flag raised by any error state condition
// - enable register per flag, reset zero, upper byte reads zero
// - tx counter in 15:8, rx counter in 7:0, reset zero
// - time quantum is 2 times (prescaler plus one) clocks
// - mode changes only after eleven recessive bits of idle bus; out of configuration or disable the code switches at once
// - configuration: no traffic, counters cleared, flags kept
// - listen only: passive, no ack, counters frozen
// - listen all: errors ignored, every message accepted
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "can_regs_defines.vh"
module can_ctrl_status (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [5:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire tx_stream,
	input wire bit_strobe,
	input wire rx_pin_in,
	output reg tx_pin_out,
	output reg tx_pin_oe,
	output reg pins_owned,
	output reg rx_stream,
	input wire chip_idle,
	output reg module_run,
	output reg abort_all_transmits,
	input wire all_tx_aborted,
	output reg capture_event,
	output reg window_select,
	input wire [4:0] dn_count_in,
	output reg [4:0] data_byte_filter_count,
	output reg ack_enable,
	output reg accept_all,
	output reg [2:0] mode_in_force,
	input wire ev_invalid,
	input wire ev_wake,
	input wire ev_fifo_af,
	input wire ev_overflow,
	input wire ev_rx,
	input wire [3:0] rx_filter,
	input wire [3:0] rx_buffer,
	input wire ev_tx,
	input wire [2:0] tx_buffer,
	input wire [5:0] fifo_wr_in,
	input wire [5:0] fifo_rd_in,
	input wire tx_err_up,
	input wire tx_err_down,
	input wire rx_err_up,
	input wire rx_err_down,
	output reg irq,
	output reg tq_tick
);
	// ***********************************
	// register state
	// ***********************************
	reg idle_stop_reg;
	reg [2:0] req_reg;
	reg capture_en_reg;
	reg [4:0] hit_reg;
	reg [6:0] code_reg;
	reg [6:0] code_next;
	reg [7:0] fifo_ctrl_reg;
	reg [5:0] fifo_wr_reg;
	reg [5:0] fifo_rd_reg;
	reg [7:0] flag_reg;
	reg [7:0] flag_next;
	reg [7:0] enable_reg;
	reg [7:0] terr_reg;
	reg [7:0] rerr_reg;
	reg [7:0] timing_one_reg;
	reg [14:0] timing_two_reg;
	reg [3:0] rx_buf_reg;
	reg [2:0] tx_buf_reg;
	reg [3:0] idle_cnt_reg;
	reg [6:0] tq_cnt_reg;
	reg [5:0] estate_reg;
	reg [31:0] rd_next;
	reg rd_err;
	wire bus_idle;
	wire wr;
	wire counting;
	wire in_config;
	wire [5:0] estate;
	wire [7:0] flag_set;
	wire [7:0] flag_keep;
	wire [6:0] tq_end;

	// ***********************************
	// apb slave: answer one cycle after setup
	// ***********************************
	assign wr = psel & penable & pready & pwrite;
	assign in_config = (mode_in_force == `M_CONFIG);

	always @*
	begin
		rd_next = 32'h0;
		rd_err = 1'b0;
		case (paddr)
			`A_CTRL_ONE:
			begin
				rd_next[`B_IDLE_STOP] = idle_stop_reg;
				rd_next[`B_ABORT] = abort_all_transmits;
				rd_next[`F_REQ] = req_reg;
				rd_next[`F_MODE] = mode_in_force;
				rd_next[`B_CAPTURE] = capture_en_reg;
				rd_next[`B_WINDOW] = window_select;
			end
			`A_CTRL_TWO: rd_next[4:0] = data_byte_filter_count;
			`A_VEC: rd_next[15:0] = {3'h0, hit_reg, 1'b0, code_reg};
			`A_FIFO_CTRL: rd_next[15:0] = {fifo_ctrl_reg[7:5], 8'h0,
				fifo_ctrl_reg[4:0]};
			`A_FIFO_STAT: rd_next[13:0] = {fifo_wr_reg, 2'h0,
				fifo_rd_reg};
			`A_INTF: rd_next[13:0] = {estate_reg, flag_reg};
			`A_INTE: rd_next[7:0] = enable_reg;
			`A_ERRCNT: rd_next[15:0] = {terr_reg, rerr_reg};
			`A_TIMING_ONE: rd_next[7:0] = timing_one_reg;
			`A_TIMING_TWO: rd_next[14:0] = timing_two_reg;
			default: rd_err = 1'b1;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel & ~penable & ~pready;
			prdata <= (psel & ~penable & ~pwrite & ~rd_err) ?
				rd_next : 32'h0;
			pslverr <= psel & ~penable & rd_err;
		end
	end

	// ***********************************
	// control register and mode
	// ***********************************
	// idle detect: eleven recessive bits seen on the receive stream
	assign bus_idle = (idle_cnt_reg == `IDLE_BITS);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			idle_stop_reg <= 1'b0;
			abort_all_transmits <= 1'b0;
			req_reg <= `M_CONFIG;
			mode_in_force <= `M_CONFIG;
			capture_en_reg <= 1'b0;
			window_select <= 1'b0;
			idle_cnt_reg <= 4'h0;
		end
		else
		begin
			if (bit_strobe)
			begin
				if (!rx_stream)
					idle_cnt_reg <= 4'h0;
				else if (!bus_idle)
					idle_cnt_reg <= idle_cnt_reg + 4'h1;
			end
			// an off-line module may switch at once, nothing to disturb
			if (req_reg != mode_in_force &&
				(bus_idle || in_config || mode_in_force == `M_DISABLE))
				mode_in_force <= req_reg;
			if (wr && paddr == `A_CTRL_ONE)
			begin
				idle_stop_reg <= pwdata[`B_IDLE_STOP];
				req_reg <= pwdata[`F_REQ];
				capture_en_reg <= pwdata[`B_CAPTURE];
				window_select <= pwdata[`B_WINDOW];
			end
			// a fresh write of one beats the self clear
			if (wr && paddr == `A_CTRL_ONE && pwdata[`B_ABORT])
				abort_all_transmits <= 1'b1;
			else if (all_tx_aborted)
				abort_all_transmits <= 1'b0;
		end
	end

	// ***********************************
	// pins, loopback and mode effects
	// ***********************************
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_pin_out <= 1'b1;
			tx_pin_oe <= 1'b0;
			pins_owned <= 1'b0;
			rx_stream <= 1'b1;
			module_run <= 1'b1;
			ack_enable <= 1'b0;
			accept_all <= 1'b0;
			capture_event <= 1'b0;
			data_byte_filter_count <= 5'h0;
		end
		else
		begin
			module_run <= ~(idle_stop_reg & chip_idle);
			case (mode_in_force)
				`M_LOOPBACK: rx_stream <= tx_stream;
				`M_NORMAL, `M_LISTEN, `M_LISTEN_ALL:
					rx_stream <= rx_pin_in;
				default: rx_stream <= 1'b1;
			endcase
			pins_owned <= (mode_in_force == `M_NORMAL) |
				(mode_in_force == `M_LISTEN) |
				(mode_in_force == `M_LISTEN_ALL);
			// only normal mode may drive the bus; listen modes stay passive
			tx_pin_oe <= (mode_in_force == `M_NORMAL);
			tx_pin_out <= (mode_in_force == `M_NORMAL) ? tx_stream : 1'b1;
			ack_enable <= (mode_in_force == `M_NORMAL) |
				(mode_in_force == `M_LOOPBACK);
			accept_all <= (mode_in_force == `M_LISTEN_ALL);
			capture_event <= ev_rx & capture_en_reg;
			// invalid selections compare no data rather than overrun
			data_byte_filter_count <= (dn_count_in > `DN_MAX) ?
				5'h0 : dn_count_in;
		end
	end

	// ***********************************
	// error counters and error state
	// ***********************************
	assign counting = (mode_in_force == `M_NORMAL) |
		(mode_in_force == `M_LOOPBACK);
	assign estate[5] = (terr_reg == `BUSOFF_LEVEL);
	assign estate[4] = (terr_reg >= `PASSIVE_LEVEL);
	assign estate[3] = (rerr_reg >= `PASSIVE_LEVEL);
	assign estate[2] = (terr_reg >= `WARN_LEVEL);
	assign estate[1] = (rerr_reg >= `WARN_LEVEL);
	assign estate[0] = estate[2] | estate[1];

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			terr_reg <= 8'h0;
			rerr_reg <= 8'h0;
			estate_reg <= 6'h0;
		end
		else
		begin
			estate_reg <= estate;
			if (in_config)
			begin
				terr_reg <= 8'h0;
				rerr_reg <= 8'h0;
			end
			else if (counting)
			begin
				// saturate so a long error burst never wraps to zero
				if (tx_err_up)
					terr_reg <= (terr_reg > `BUSOFF_LEVEL - `ERR_STEP) ?
						`BUSOFF_LEVEL : terr_reg + `ERR_STEP;
				else if (tx_err_down && terr_reg != 8'h0)
					terr_reg <= terr_reg - 8'h1;
				if (rx_err_up && rerr_reg != `BUSOFF_LEVEL)
					rerr_reg <= rerr_reg + 8'h1;
				else if (rx_err_down && rerr_reg != 8'h0)
					rerr_reg <= rerr_reg - 8'h1;
			end
		end
	end

	// ***********************************
	// interrupt flags, enables and code
	// ***********************************
	assign flag_set[`B_INVALID] = ev_invalid;
	assign flag_set[`B_WAKE] = ev_wake;
	assign flag_set[`B_ERROR] = |(estate & ~estate_reg);
	assign flag_set[4] = 1'b0;
	assign flag_set[`B_FIFO_AF] = ev_fifo_af;
	assign flag_set[`B_OVERFLOW] = ev_overflow;
	assign flag_set[`B_RXBUF] = ev_rx;
	assign flag_set[`B_TXBUF] = ev_tx;
	assign flag_keep = (wr && paddr == `A_INTF) ?
		(flag_reg & pwdata[7:0]) : flag_reg;

	always @*
	begin
		// set beats a clear landing in the same cycle
		flag_next = (flag_keep | flag_set) & `FLAG_MASK;
		if (flag_reg[`B_ERROR])
			code_next = `IC_ERROR;
		else if (flag_reg[`B_WAKE])
			code_next = `IC_WAKE;
		else if (flag_reg[`B_OVERFLOW])
			code_next = `IC_OVERFLOW;
		else if (flag_reg[`B_FIFO_AF])
			code_next = `IC_FIFO_AF;
		else if (flag_reg[`B_RXBUF])
			code_next = `IC_RXBASE | {3'h0, rx_buf_reg};
		else if (flag_reg[`B_TXBUF])
			code_next = {4'h0, tx_buf_reg};
		else
			code_next = `IC_NONE;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flag_reg <= 8'h0;
			enable_reg <= 8'h0;
			code_reg <= `IC_NONE;
			hit_reg <= 5'h0;
			rx_buf_reg <= 4'h0;
			tx_buf_reg <= 3'h0;
			fifo_wr_reg <= 6'h0;
			fifo_rd_reg <= 6'h0;
			irq <= 1'b0;
		end
		else
		begin
			flag_reg <= flag_next;
			code_reg <= code_next;
			irq <= |(flag_reg & enable_reg);
			fifo_wr_reg <= fifo_wr_in;
			fifo_rd_reg <= fifo_rd_in;
			if (wr && paddr == `A_INTE)
				enable_reg <= pwdata[7:0] & `FLAG_MASK;
			if (ev_rx)
			begin
				hit_reg <= {1'b0, rx_filter};
				rx_buf_reg <= rx_buffer;
			end
			if (ev_tx)
				tx_buf_reg <= tx_buffer;
		end
	end

	// ***********************************
	// configuration registers and quantum divider
	// ***********************************
	// tick every 2*(prescaler+1) clocks
	assign tq_end = {timing_one_reg[5:0], 1'b1};

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fifo_ctrl_reg <= 8'h0;
			timing_one_reg <= 8'h0;
			timing_two_reg <= 15'h0;
			tq_cnt_reg <= 7'h0;
			tq_tick <= 1'b0;
		end
		else
		begin
			// timing and fifo setup lock while on-line
			if (wr && in_config && paddr == `A_FIFO_CTRL)
				fifo_ctrl_reg <= {pwdata[15:13], pwdata[4:0]};
			if (wr && in_config && paddr == `A_TIMING_ONE)
				timing_one_reg <= pwdata[7:0];
			if (wr && in_config && paddr == `A_TIMING_TWO)
				timing_two_reg <= pwdata[14:0] & 15'h47FF;
			if (tq_cnt_reg >= tq_end)
			begin
				tq_cnt_reg <= 7'h0;
				tq_tick <= module_run;
			end
			else
			begin
				tq_cnt_reg <= tq_cnt_reg + 7'h1;
				tq_tick <= 1'b0;
			end
		end
	end
endmodule

//--- dv/can_bus_node.sv
// model of the other nodes on the bus: bit timing and bus level
`timescale 1ns/100ps
module can_bus_node #(
	parameter BIT_CLKS = 4
) (
	input logic pclk,
	input logic presetn,
	input logic dominant,
	output logic rx_pin_in,
	output logic bit_strobe
);
	logic [7:0] div;
	// the bus is pulled recessive unless some node drives it dominant
	assign rx_pin_in = !dominant;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div <= 8'h00;
			bit_strobe <= 1'h0;
		end
		else
		begin
			bit_strobe <= (div == BIT_CLKS - 1);
			div <= (div == BIT_CLKS - 1) ? 8'h00 : div + 8'h01;
		end
	end
endmodule

//--- dv/can_ctrl_status_sva.sv
// assertion checker for the can control and status block
`timescale 1ns/100ps
`include "can_regs_defines.vh"
module can_ctrl_status_sva (
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pready,
	input logic pwrite,
	input logic [5:0] paddr,
	input logic [31:0] pwdata,
	input logic tx_stream,
	input logic bit_strobe,
	input logic rx_stream,
	input logic tx_pin_out,
	input logic tx_pin_oe,
	input logic pins_owned,
	input logic chip_idle,
	input logic module_run,
	input logic abort_all_transmits,
	input logic ev_rx,
	input logic capture_event,
	input logic [4:0] data_byte_filter_count,
	input logic [2:0] mode_in_force,
	input logic tq_tick
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ***********************************
	// idle bus tracking
	// ***********************************
	logic [3:0] idle_cnt;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			idle_cnt <= 4'h0;
		else if (bit_strobe && !rx_stream)
			idle_cnt <= 4'h0;
		else if (bit_strobe && idle_cnt != 4'hB)
			idle_cnt <= idle_cnt + 4'h1;
	end
	// ***********************************
	// properties
	// ***********************************
	property p_loop_route;
		(mode_in_force == `M_LOOPBACK && $past(mode_in_force) == `M_LOOPBACK)
		|-> rx_stream == $past(tx_stream);
	endproperty
	a_loop_route: assert property (p_loop_route) else $error("loop route");
	property p_loop_pins;
		(mode_in_force == `M_LOOPBACK && $past(mode_in_force) == `M_LOOPBACK)
		|-> !pins_owned && !tx_pin_oe && tx_pin_out;
	endproperty
	a_loop_pins: assert property (p_loop_pins) else $error("pins held");
	property p_idle_halt;
		!module_run |-> $past(chip_idle);
	endproperty
	a_idle_halt: assert property (p_idle_halt) else $error("bad halt");
	property p_abort_set;
		$rose(abort_all_transmits)
		|-> $past(psel && penable && pready && pwrite &&
		paddr == `A_CTRL_ONE && pwdata[`B_ABORT]);
	endproperty
	a_abort_set: assert property (p_abort_set) else $error("abort");
	property p_capture;
		capture_event |-> $past(ev_rx);
	endproperty
	a_capture: assert property (p_capture) else $error("capture");
	property p_dn_range;
		data_byte_filter_count <= `DN_MAX;
	endproperty
	a_dn_range: assert property (p_dn_range) else $error("dn range");
	property p_tq_gap;
		tq_tick |=> !tq_tick;
	endproperty
	a_tq_gap: assert property (p_tq_gap) else $error("tq gap");
	// the count seen at the switching edge must already be full
	property p_idle_wait;
		($changed(mode_in_force) && $past(mode_in_force) != `M_CONFIG
		&& $past(mode_in_force) != `M_DISABLE)
		|-> $past(idle_cnt) == `IDLE_BITS;
	endproperty
	a_idle_wait: assert property (p_idle_wait) else $error("no idle");
endmodule
bind can_ctrl_status can_ctrl_status_sva chk_i (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pready(pready),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.tx_stream(tx_stream),
	.bit_strobe(bit_strobe),
	.rx_stream(rx_stream),
	.tx_pin_out(tx_pin_out),
	.tx_pin_oe(tx_pin_oe),
	.pins_owned(pins_owned),
	.chip_idle(chip_idle),
	.module_run(module_run),
	.abort_all_transmits(abort_all_transmits),
	.ev_rx(ev_rx),
	.capture_event(capture_event),
	.data_byte_filter_count(data_byte_filter_count),
	.mode_in_force(mode_in_force),
	.tq_tick(tq_tick)
);

//--- dv/test_can_ctrl_status.sv
// self-checking testbench of the can control and status block
`timescale 1ns/100ps
`include "can_regs_defines.vh"
module test_can_ctrl_status;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, tx_stream = 1'h1, chip_idle = 1'h0, dominant = 1'h0;
	logic all_tx_aborted = 1'h0, ev_invalid = 1'h0, ev_wake = 1'h0;
	logic ev_fifo_af = 1'h0, ev_overflow = 1'h0, ev_rx = 1'h0, ev_tx = 1'h0;
	logic tx_err_up = 1'h0, tx_err_down = 1'h0;
	logic rx_err_up = 1'h0, rx_err_down = 1'h0;
	logic [5:0] paddr = 6'h00, fifo_wr_in = 6'h1F, fifo_rd_in = 6'h05;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [4:0] dn_count_in = 5'h00, data_byte_filter_count;
	logic [3:0] rx_filter = 4'hA, rx_buffer = 4'h9;
	logic [2:0] tx_buffer = 3'h2, mode_in_force;
	logic pready, pslverr, rx_pin_in, tx_pin_out, tx_pin_oe, pins_owned;
	logic rx_stream, module_run, abort_all_transmits, capture_event;
	logic window_select, ack_enable, accept_all, irq, tq_tick, bit_strobe;
	int fails = 0, checked = 0;
	can_ctrl_status DUT (
		.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.tx_stream(tx_stream), .bit_strobe(bit_strobe),
		.rx_pin_in(rx_pin_in), .tx_pin_out(tx_pin_out),
		.tx_pin_oe(tx_pin_oe), .pins_owned(pins_owned),
		.rx_stream(rx_stream), .chip_idle(chip_idle),
		.module_run(module_run),
		.abort_all_transmits(abort_all_transmits),
		.all_tx_aborted(all_tx_aborted),
		.capture_event(capture_event),
		.window_select(window_select),
		.dn_count_in(dn_count_in),
		.data_byte_filter_count(data_byte_filter_count),
		.ack_enable(ack_enable), .accept_all(accept_all),
		.mode_in_force(mode_in_force),
		.ev_invalid(ev_invalid), .ev_wake(ev_wake),
		.ev_fifo_af(ev_fifo_af), .ev_overflow(ev_overflow),
		.ev_rx(ev_rx), .rx_filter(rx_filter),
		.rx_buffer(rx_buffer), .ev_tx(ev_tx),
		.tx_buffer(tx_buffer), .fifo_wr_in(fifo_wr_in),
		.fifo_rd_in(fifo_rd_in), .tx_err_up(tx_err_up),
		.tx_err_down(tx_err_down), .rx_err_up(rx_err_up),
		.rx_err_down(rx_err_down), .irq(irq),
		.tq_tick(tq_tick)
	);
	can_bus_node node (
		.pclk(pclk),
		.presetn(presetn),
		.dominant(dominant),
		.rx_pin_in(rx_pin_in),
		.bit_strobe(bit_strobe)
	);
	always #2 pclk = ~pclk;
	// ***********************************
	// shared tasks
	// ***********************************
	task automatic end_of_test;
		if (fails == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [5:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'h1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n == 20)
			chk(32'h0, 32'h1);
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'h1, a, d, r, e);
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'h0, a, 32'h0, r, e);
		chk(r, x);
	endtask
	// ***********************************
	// scenarios
	// ***********************************
	task automatic t_reset;
		logic [31:0] r;
		logic e;
		rd(`A_CTRL_ONE, 32'h0480);
		rd(`A_VEC, 32'h0040);
		rd(`A_ERRCNT, 32'h0);
		rd(`A_INTE, 32'h0);
		apb(1'h0, 6'h28, 32'h0, r, e);
		chk(e, 32'h1);
	endtask
	task automatic t_quantum;
		int n;
		wr(`A_TIMING_ONE, 32'h3);
		rd(`A_TIMING_ONE, 32'h3);
		cyc(10);
		while (tq_tick !== 1'h1)
			@(posedge pclk);
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (tq_tick !== 1'h1 && n < 200);
		chk(n, 32'h8);
	endtask
	task automatic t_loopback;
		wr(`A_CTRL_ONE, 32'h0208);
		rd(`A_CTRL_ONE, 32'h0248);
		tx_stream <= 1'h0;
		cyc(3);
		chk(rx_stream, 32'h0);
		chk({pins_owned, tx_pin_oe}, 32'h0);
	endtask
	task automatic t_mode_wait;
		wr(`A_CTRL_ONE, 32'h0008);
		cyc(60);
		rd(`A_CTRL_ONE, 32'h0048);
		tx_stream <= 1'h1;
		cyc(60);
		rd(`A_CTRL_ONE, 32'h0008);
		chk(tx_pin_oe, 32'h1);
		dominant <= 1'h1;
		cyc(3);
		chk(rx_stream, 32'h0);
		dominant <= 1'h0;
	endtask
	task automatic t_flags;
		wr(`A_INTE, 32'hFFFF);
		rd(`A_INTE, 32'h00EF);
		{ev_invalid, ev_wake, ev_fifo_af, ev_overflow, ev_rx, ev_tx} <= 6'h3F;
		@(posedge pclk);
		{ev_invalid, ev_wake, ev_fifo_af, ev_overflow, ev_rx, ev_tx} <= 6'h00;
		@(posedge pclk);
		chk(capture_event, 32'h1);
		cyc(2);
		chk(irq, 32'h1);
		rd(`A_INTF, 32'h00CF);
		rd(`A_VEC, 32'h0A42);
		wr(`A_INTF, 32'hFFBF);
		rd(`A_INTF, 32'h008F);
		rd(`A_VEC, 32'h0A43);
		wr(`A_INTF, 32'h0000);
		wr(`A_INTF, 32'hFFFF);
		rd(`A_INTF, 32'h0);
		rd(`A_VEC, 32'h0A40);
		chk(irq, 32'h0);
	endtask
	task automatic t_abort;
		wr(`A_CTRL_ONE, 32'h1008);
		cyc(1);
		chk(abort_all_transmits, 32'h1);
		all_tx_aborted <= 1'h1;
		cyc(3);
		chk(abort_all_transmits, 32'h0);
		all_tx_aborted <= 1'h0;
		rd(`A_CTRL_ONE, 32'h0008);
		wr(`A_CTRL_ONE, 32'h0009);
		cyc(1);
		chk(window_select, 32'h1);
	endtask
	task automatic t_idle;
		chip_idle <= 1'h1;
		cyc(3);
		chk(module_run, 32'h1);
		wr(`A_CTRL_ONE, 32'h2008);
		cyc(3);
		chk(module_run, 32'h0);
		chip_idle <= 1'h0;
		cyc(3);
		chk(module_run, 32'h1);
		wr(`A_CTRL_ONE, 32'h0008);
	endtask
	task automatic t_status;
		dn_count_in <= 5'h12;
		cyc(3);
		chk(data_byte_filter_count, 32'h0);
		dn_count_in <= 5'h11;
		cyc(3);
		rd(`A_CTRL_TWO, 32'h11);
		rd(`A_FIFO_STAT, 32'h1F05);
		wr(`A_TIMING_ONE, 32'h5);
		rd(`A_TIMING_ONE, 32'h3);
	endtask
	task automatic t_errors;
		{tx_err_up, rx_err_up} <= 2'h3;
		cyc(12);
		{tx_err_up, rx_err_up} <= 2'h0;
		cyc(3);
		rd(`A_ERRCNT, 32'h600C);
		rd(`A_INTF, 32'h0520);
		rd(`A_VEC, 32'h0A41);
		wr(`A_INTF, 32'h0000);
		rd(`A_INTF, 32'h0500);
		wr(`A_CTRL_ONE, 32'h0408);
		rd(`A_CTRL_ONE, 32'h0488);
		rd(`A_ERRCNT, 32'h0);
	endtask
	task automatic t_modes;
		wr(`A_CTRL_ONE, 32'h0708);
		cyc(3);
		chk({accept_all, ack_enable, tx_pin_oe, pins_owned}, 32'h9);
		wr(`A_CTRL_ONE, 32'h0308);
		cyc(3);
		chk({accept_all, ack_enable, tx_pin_oe, pins_owned}, 32'h1);
		chk(tx_pin_out, 32'h1);
		wr(`A_CTRL_ONE, 32'h0108);
		cyc(3);
		chk({accept_all, ack_enable, tx_pin_oe, pins_owned}, 32'h0);
		wr(`A_CTRL_ONE, 32'h0008);
		cyc(3);
		chk({accept_all, ack_enable, tx_pin_oe, pins_owned}, 32'h7);
	endtask
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		t_reset;
		t_quantum;
		t_loopback;
		t_mode_wait;
		t_flags;
		t_errors;
		t_modes;
		t_abort;
		t_idle;
		t_status;
		end_of_test;
	end
	initial
	begin
		#20000;
		fails++;
		end_of_test;
	end
endmodule
